/* File: bl_reg_pkg.sv */
// Shared constants, types and state encodings for the backlight serial register block.
// Assumes a single 40 MHz reference clock and a serial clock arriving from the host.
package bl_reg_pkg;

	// Register offsets, as carried in the serial register-address byte.
	localparam logic [7:0] OFS_BRIGHTNESS = 8'h00;
	localparam logic [7:0] OFS_CURRENT = 8'h02;
	localparam logic [7:0] OFS_CFG_ONE = 8'h04;
	localparam logic [7:0] OFS_CFG_TWO = 8'h06;
	localparam logic [7:0] OFS_SUPPLY_EN = 8'h08;
	localparam logic [7:0] OFS_BOOST_EN = 8'h0a;
	localparam logic [7:0] OFS_LED_EN = 8'h0c;
	localparam logic [7:0] OFS_SUPPLY_ST = 8'h0e;
	localparam logic [7:0] OFS_BOOST_ST = 8'h10;
	localparam logic [7:0] OFS_LED_ST = 8'h12;
	localparam logic [7:0] OFS_FSM_DIAG = 8'h14;
	localparam logic [7:0] OFS_PWM_IN_DIAG = 8'h16;
	localparam logic [7:0] OFS_PWM_OUT_DIAG = 8'h18;
	localparam logic [7:0] OFS_CURR_DIAG = 8'h1a;
	localparam logic [7:0] OFS_BOOST_DIAG = 8'h1c;
	localparam logic [7:0] OFS_DETECT_DIAG = 8'h1e;

	// Values after reset.
	localparam logic [15:0] BRIGHTNESS_RST = 16'h0000;
	localparam logic [15:0] CURRENT_RST = 16'h0fff;
	localparam logic [15:0] CFG_ONE_RST = 16'h08a3;
	localparam logic [15:0] CFG_TWO_RST = 16'h0001;
	localparam logic [7:0] IRQ_EN_RST = 8'hff;

	// Field positions.
	localparam int SRC_SEL_LSB = 8;
	localparam int DITHER_LSB = 1;
	localparam int GLOBAL_EN_BIT = 0;
	localparam int SERIAL_ERR_BIT = 7;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_REGISTER = 2'h2;

	// The two target addresses, picked by the mode-select resistor.
	localparam logic [6:0] TARGET_ADDR_LOW = 7'h3a;
	localparam logic [6:0] TARGET_ADDR_HIGH = 7'h3b;

	// Serial timeout, as a time and as reference cycles.
	localparam int REF_CLK_HZ = 40000000;
	localparam int SERIAL_TIMEOUT_MS = 500;
	localparam int SERIAL_TIMEOUT_CYC = SERIAL_TIMEOUT_MS * (REF_CLK_HZ / 1000);

	// Fault event pulses from the protection logic, one bit per fault.
	typedef struct packed {
		logic [7:0] supply;
		logic [7:0] boost;
		logic [7:0] led;
	} fault_s;

	// Live values from the core that the diagnostic registers show.
	typedef struct packed {
		logic [15:0] stateMachineNow;
		logic [15:0] pwmInputDuty;
		logic [15:0] pwmOutputDuty;
		logic [11:0] appliedCurrentCode;
		logic [9:0] boostTargetCode;
		logic [15:0] detectResult;
	} diag_s;

	// Serial byte engine states.
	typedef enum logic [2:0] {LS_WAIT, LS_DEVADR, LS_REGADR, LS_WDATA, LS_RDATA, LS_IGNORE} link_state_e;

endpackage

/* File: backlight_i2c_regs.sv */
// Serial register interface of an LED backlight driver: byte engine on the serial clock,
// register bank, fault flags and interrupt on the 40 MHz reference clock.
// Assumes fault pulses, diagnostics and the state-window level come from ref_clk logic.
`timescale 1ns/1ps

// Three-stage synchroniser; the output follows once stages two and three agree.
module sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic [2:0] stage_r;
	// Shift chain; only stage one sees the asynchronous input.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stage_r <= {3{RST_VAL}};
		else
			stage_r <= {stage_r[1:0], din};
	end
	// Filtered output.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dout <= RST_VAL;
		else if (stage_r[1] == stage_r[2])
			dout <= stage_r[2];
	end
endmodule

module backlight_i2c_regs #(
	parameter int unsigned TIMEOUT_CYCLES = bl_reg_pkg::SERIAL_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addrSelect,
	input wire logic writeAllowed,
	input wire logic enableLevel,
	input wire bl_reg_pkg::fault_s faultIn,
	input wire bl_reg_pkg::diag_s diagIn,
	output logic [15:0] brightnessValue,
	output logic [11:0] currentSetting,
	output logic [2:0] ditherSelect,
	output logic [15:0] cfgOneWord,
	output logic [15:0] cfgTwoWord,
	output logic faultIrq
);
	bl_reg_pkg::link_state_e state_r;
	logic [3:0] bitCnt_r;
	logic [1:0] byteIdx_r;
	logic [7:0] shift_r, regPtr_r, hiByte_r, wrPtr_r, rxNow;
	logic [15:0] wrWord_r, txWord_r, rdSnap_r, rdWord;
	logic ackPend_r, rw_r, sdaPos_r, wrTog_r, ptrTog_r;
	logic startPend_r, armed_r, oeLink_r, byteDone, ackClk, txBit;
	logic [6:0] myAddr;
	logic sclS, sdaS, wrTogS, ptrTogS, sclPrev_r, sdaPrev_r, wrTogPrev_r, ptrTogPrev_r;
	logic startRef, stopRef, wrEvt, ptrEvt, busy_r, tmoHold_r, tmoEvt;
	logic [24:0] tmoCnt_r;
	logic [15:0] brightness_r, current_r, cfgOne_r, cfgTwo_r, brightnessValue_r;
	logic [2:0][7:0] irqEn_r, flags_r, setVec;
	logic faultIrq_r;
	logic stopTog_r, stopSeen_r, startNow;

	// Two-bit field readback: enabled or set shows as binary 10.
	function automatic logic [15:0] spread(input logic [7:0] v);
		logic [15:0] w;
		w = 16'h0000;
		for (int k = 0; k < 8; k++)
			w[2 * k + 1] = v[k];
		return w;
	endfunction

	// Target address follows the detected mode-select resistor level.
	// address select
	assign myAddr = addrSelect ? bl_reg_pkg::TARGET_ADDR_HIGH : bl_reg_pkg::TARGET_ADDR_LOW;
	assign rxNow = {shift_r[6:0], sdaIn};
	assign byteDone = !startPend_r && bitCnt_r == 4'h7;
	assign ackClk = !startPend_r && bitCnt_r == 4'h8;
	assign txBit = txWord_r[4'hf - {byteIdx_r[0], bitCnt_r[2:0]}];

	// Byte engine on serial rising edges; the engine must live here because a 160 ns
	// serial period leaves no time to resynchronise each bit into the reference domain.
	always_ff @(posedge scl or posedge rst)
	begin
		if (rst)
		begin
			state_r <= bl_reg_pkg::LS_WAIT;
			bitCnt_r <= 4'h0;
			byteIdx_r <= 2'h0;
			shift_r <= 8'h00;
			ackPend_r <= 1'b0;
			rw_r <= 1'b0;
			sdaPos_r <= 1'b1;
		end
		else
		begin
			sdaPos_r <= sdaIn;
			shift_r <= rxNow;
			if (startPend_r)
			begin
				state_r <= bl_reg_pkg::LS_DEVADR;
				bitCnt_r <= 4'h1;
				byteIdx_r <= 2'h0;
				ackPend_r <= 1'b0;
			end
			else
			begin
				bitCnt_r <= ackClk ? 4'h0 : bitCnt_r + 4'h1;
				if (byteDone)
				begin
					case (state_r)
						bl_reg_pkg::LS_DEVADR:
						begin
							if (rxNow[7:1] == myAddr)
							begin
								ackPend_r <= 1'b1;
								rw_r <= rxNow[0];
							end
							else
								state_r <= bl_reg_pkg::LS_IGNORE;
						end
						bl_reg_pkg::LS_REGADR: ackPend_r <= 1'b1;
						bl_reg_pkg::LS_WDATA: ackPend_r <= 1'b1;
						default: ackPend_r <= 1'b0;
					endcase
				end
				if (ackClk)
				begin
					ackPend_r <= 1'b0;
					case (state_r)
						bl_reg_pkg::LS_DEVADR:
							state_r <= rw_r ? bl_reg_pkg::LS_RDATA : bl_reg_pkg::LS_REGADR;
						bl_reg_pkg::LS_REGADR: state_r <= bl_reg_pkg::LS_WDATA;
						bl_reg_pkg::LS_WDATA:
						begin
							byteIdx_r <= byteIdx_r + 2'h1;
							if (byteIdx_r[0])
								state_r <= bl_reg_pkg::LS_WAIT;
						end
						bl_reg_pkg::LS_RDATA:
						begin
							byteIdx_r <= byteIdx_r + 2'h1;
							if (sdaIn || byteIdx_r[0])
								state_r <= bl_reg_pkg::LS_WAIT;
						end
						// A foreign frame stays ignored until the next start or stop.
						bl_reg_pkg::LS_IGNORE: state_r <= bl_reg_pkg::LS_IGNORE;
						default: state_r <= bl_reg_pkg::LS_WAIT;
					endcase
				end
			end
		end
	end

	// Pointer, write word and read word capture; the pointer and write handoffs toggle a flag, and the
	// word stays still long after the toggle, so the reference side reads it safely.
	always_ff @(posedge scl or posedge rst)
	begin
		if (rst)
		begin
			regPtr_r <= 8'h00;
			hiByte_r <= 8'h00;
			wrPtr_r <= 8'h00;
			wrWord_r <= 16'h0000;
			txWord_r <= 16'h0000;
			wrTog_r <= 1'b0;
			ptrTog_r <= 1'b0;
		end
		else
		begin
			if (byteDone && state_r == bl_reg_pkg::LS_REGADR)
			begin
				regPtr_r <= rxNow;
				ptrTog_r <= ~ptrTog_r;
			end
			if (byteDone && state_r == bl_reg_pkg::LS_WDATA && byteIdx_r == 2'h0)
				hiByte_r <= rxNow;
			if (byteDone && state_r == bl_reg_pkg::LS_WDATA && byteIdx_r == 2'h1)
			begin
				wrWord_r <= {hiByte_r, rxNow};
				wrPtr_r <= regPtr_r;
				wrTog_r <= ~wrTog_r;
			end
			if (ackClk && state_r == bl_reg_pkg::LS_DEVADR && rw_r)
				txWord_r <= rdSnap_r;
		end
	end

	// Falling edges: start detection and data line drive. A stop gives no serial edge, so
	// the reference side toggles on each stop and the next falling edge opens a new frame.
	// The toggle settles long before that edge, because bus free time follows every stop.
	assign startNow = armed_r || (stopTog_r ^ stopSeen_r) || (sdaPos_r && !sdaIn);
	always_ff @(negedge scl or posedge rst)
	begin
		if (rst)
		begin
			startPend_r <= 1'b0;
			armed_r <= 1'b1;
			stopSeen_r <= 1'b0;
			oeLink_r <= 1'b0;
		end
		else
		begin
			startPend_r <= startNow;
			armed_r <= 1'b0;
			stopSeen_r <= stopTog_r;
			if (startNow)
				oeLink_r <= 1'b0;
			else
				oeLink_r <= ackPend_r || (state_r == bl_reg_pkg::LS_RDATA && !bitCnt_r[3] && !txBit);
		end
	end

	// Open-drain data: only ever pulls low; a timeout forces release of a stuck bus.
	assign sdaOut = 1'b0;
	assign sdaOe = oeLink_r && !tmoHold_r;

	sync3 #(.RST_VAL(1'b1)) syncScl (.clk(ref_clk), .rst(rst), .din(scl), .dout(sclS));
	sync3 #(.RST_VAL(1'b1)) syncSda (.clk(ref_clk), .rst(rst), .din(sdaIn), .dout(sdaS));
	sync3 syncWr (.clk(ref_clk), .rst(rst), .din(wrTog_r), .dout(wrTogS));
	sync3 syncPtr (.clk(ref_clk), .rst(rst), .din(ptrTog_r), .dout(ptrTogS));

	// Edge history of the synchronised bus and handoff toggles.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			wrTogPrev_r <= 1'b0;
			ptrTogPrev_r <= 1'b0;
			stopTog_r <= 1'b0;
		end
		else
		begin
			sclPrev_r <= sclS;
			sdaPrev_r <= sdaS;
			wrTogPrev_r <= wrTogS;
			ptrTogPrev_r <= ptrTogS;
			if (stopRef)
				stopTog_r <= ~stopTog_r;
		end
	end
	assign startRef = sclS && sclPrev_r && sdaPrev_r && !sdaS;
	assign stopRef = sclS && sclPrev_r && !sdaPrev_r && sdaS;
	assign wrEvt = wrTogS ^ wrTogPrev_r;
	assign ptrEvt = ptrTogS ^ ptrTogPrev_r;
	assign tmoEvt = busy_r && tmoCnt_r == 25'(TIMEOUT_CYCLES - 1);

	// Stuck-command watchdog: runs from start to stop.
	// serial timeout
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_r <= 1'b0;
			tmoCnt_r <= 25'h0000000;
			tmoHold_r <= 1'b0;
		end
		else
		begin
			if (startRef)
				busy_r <= 1'b1;
			else if (stopRef || tmoEvt)
				busy_r <= 1'b0;
			tmoCnt_r <= (startRef || !busy_r) ? 25'h0000000 : tmoCnt_r + 25'h0000001;
			if (startRef)
				tmoHold_r <= 1'b0;
			else if (tmoEvt)
				tmoHold_r <= 1'b1;
		end
	end

	// Configuration words; writes only land while the core is in its writable window.
	// config writes
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			brightness_r <= bl_reg_pkg::BRIGHTNESS_RST;
			current_r <= bl_reg_pkg::CURRENT_RST;
			cfgOne_r <= bl_reg_pkg::CFG_ONE_RST;
			cfgTwo_r <= bl_reg_pkg::CFG_TWO_RST;
		end
		else if (wrEvt && writeAllowed)
		begin
			case (wrPtr_r)
				bl_reg_pkg::OFS_BRIGHTNESS: brightness_r <= wrWord_r;
				bl_reg_pkg::OFS_CURRENT: current_r <= wrWord_r;
				bl_reg_pkg::OFS_CFG_ONE: cfgOne_r <= wrWord_r;
				bl_reg_pkg::OFS_CFG_TWO: cfgTwo_r <= wrWord_r;
				default: cfgTwo_r <= cfgTwo_r;
			endcase
		end
	end

	// Per-fault enables; 01 turns off, 11 turns on, other codes leave it alone.
	// enable fields
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irqEn_r <= {3{bl_reg_pkg::IRQ_EN_RST}};
		else if (wrEvt)
			for (int g = 0; g < 3; g++)
				for (int k = 0; k < 8; k++)
					if (wrPtr_r == bl_reg_pkg::OFS_SUPPLY_EN + 8'(2 * g))
						case (wrWord_r[2 * k +: 2])
							2'b01: irqEn_r[g][k] <= 1'b0;
							2'b11: irqEn_r[g][k] <= 1'b1;
							default: irqEn_r[g][k] <= irqEn_r[g][k];
						endcase
	end

	// Sticky fault flags; a new event wins over a clear in the same cycle.
	// flags
	assign setVec = {faultIn.led, faultIn.boost, faultIn.supply | {tmoEvt, 7'h00}};
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			flags_r <= '0;
		else
			for (int g = 0; g < 3; g++)
				for (int k = 0; k < 8; k++)
					if (setVec[g][k])
						flags_r[g][k] <= 1'b1;
					else if (wrEvt && wrPtr_r == bl_reg_pkg::OFS_SUPPLY_ST + 8'(2 * g)
						&& wrWord_r[2 * k +: 2] == 2'b11)
						flags_r[g][k] <= 1'b0;
	end

	// Read mux; reserved offsets read zero and writes to them or to diagnostics vanish.
	// readback
	always_comb
	begin
		case (regPtr_r)
			bl_reg_pkg::OFS_BRIGHTNESS: rdWord = brightness_r;
			bl_reg_pkg::OFS_CURRENT: rdWord = current_r;
			bl_reg_pkg::OFS_CFG_ONE: rdWord = cfgOne_r;
			bl_reg_pkg::OFS_CFG_TWO: rdWord = cfgTwo_r;
			bl_reg_pkg::OFS_SUPPLY_EN: rdWord = spread(irqEn_r[0]);
			bl_reg_pkg::OFS_BOOST_EN: rdWord = spread(irqEn_r[1]);
			bl_reg_pkg::OFS_LED_EN: rdWord = spread(irqEn_r[2]);
			bl_reg_pkg::OFS_SUPPLY_ST: rdWord = spread(flags_r[0]);
			bl_reg_pkg::OFS_BOOST_ST: rdWord = spread(flags_r[1]);
			bl_reg_pkg::OFS_LED_ST: rdWord = spread(flags_r[2]);
			bl_reg_pkg::OFS_FSM_DIAG: rdWord = diagIn.stateMachineNow;
			bl_reg_pkg::OFS_PWM_IN_DIAG: rdWord = diagIn.pwmInputDuty;
			bl_reg_pkg::OFS_PWM_OUT_DIAG: rdWord = diagIn.pwmOutputDuty;
			bl_reg_pkg::OFS_CURR_DIAG: rdWord = {4'h0, diagIn.appliedCurrentCode};
			bl_reg_pkg::OFS_BOOST_DIAG: rdWord = {6'h00, diagIn.boostTargetCode};
			bl_reg_pkg::OFS_DETECT_DIAG: rdWord = diagIn.detectResult;
			default: rdWord = 16'h0000;
		endcase
	end

	// Snapshot taken when a new pointer arrives, so a read never tears mid-word.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdSnap_r <= 16'h0000;
		else if (ptrEvt)
			rdSnap_r <= rdWord;
	end

	// Brightness source and interrupt output; pin control works with no serial access.
	// outputs
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			brightnessValue_r <= 16'h0000;
			faultIrq_r <= 1'b0;
		end
		else
		begin
			if (!enableLevel)
				brightnessValue_r <= 16'h0000;
			else if (cfgOne_r[bl_reg_pkg::SRC_SEL_LSB +: 2] == bl_reg_pkg::SRC_REGISTER)
				brightnessValue_r <= brightness_r;
			else
				brightnessValue_r <= diagIn.pwmInputDuty;
			faultIrq_r <= cfgTwo_r[bl_reg_pkg::GLOBAL_EN_BIT] && |(flags_r & irqEn_r);
		end
	end
	assign brightnessValue = brightnessValue_r;
	assign currentSetting = current_r[11:0];
	assign ditherSelect = cfgOne_r[bl_reg_pkg::DITHER_LSB +: 3];
	assign cfgOneWord = cfgOne_r;
	assign cfgTwoWord = cfgTwo_r;
	assign faultIrq = faultIrq_r;

	// Checks on both clock domains; each property names its own clock.
	property p_addr_miss;
		@(posedge scl) disable iff (rst)
		byteDone && state_r == bl_reg_pkg::LS_DEVADR && rxNow[7:1] != myAddr
		|=> state_r == bl_reg_pkg::LS_IGNORE && !ackPend_r;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");
	property p_ack_reg;
		@(posedge scl) disable iff (rst)
		byteDone && state_r == bl_reg_pkg::LS_REGADR |=> ackPend_r ##1 !ackPend_r;
	endproperty
	a_ack_reg: assert property (p_ack_reg) else $error("register byte not acknowledged");
	property p_cfg_gate;
		@(posedge ref_clk) disable iff (rst)
		wrEvt && !writeAllowed |=> $stable(brightness_r) && $stable(cfgOne_r);
	endproperty
	a_cfg_gate: assert property (p_cfg_gate) else $error("write outside window landed");
	property p_brt_write;
		@(posedge ref_clk) disable iff (rst)
		wrEvt && writeAllowed && wrPtr_r == bl_reg_pkg::OFS_BRIGHTNESS
		|=> brightness_r == $past(wrWord_r);
	endproperty
	a_brt_write: assert property (p_brt_write) else $error("brightness not stored");
	property p_clear_both;
		@(posedge ref_clk) disable iff (rst)
		flags_r[0][0] && !(wrEvt && wrPtr_r == bl_reg_pkg::OFS_SUPPLY_ST && wrWord_r[1:0] == 2'b11)
		|=> flags_r[0][0];
	endproperty
	a_clear_both: assert property (p_clear_both) else $error("flag cleared wrongly");
	property p_en_off;
		@(posedge ref_clk) disable iff (rst)
		wrEvt && wrPtr_r == bl_reg_pkg::OFS_LED_EN && wrWord_r[1:0] == 2'b01 |=> !irqEn_r[2][0];
	endproperty
	a_en_off: assert property (p_en_off) else $error("enable field not cleared");
	property p_global;
		@(posedge ref_clk) disable iff (rst)
		!cfgTwo_r[bl_reg_pkg::GLOBAL_EN_BIT] |=> !faultIrq_r;
	endproperty
	a_global: assert property (p_global) else $error("interrupt despite global off");
	property p_irq;
		@(posedge ref_clk) disable iff (rst)
		faultIn.led[0] && irqEn_r[2][0] && cfgTwo_r[bl_reg_pkg::GLOBAL_EN_BIT]
		##1 cfgTwo_r[bl_reg_pkg::GLOBAL_EN_BIT] |=> faultIrq_r;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled fault gave no interrupt");
	property p_src;
		@(posedge ref_clk) disable iff (rst)
		enableLevel && cfgOne_r[9:8] == bl_reg_pkg::SRC_REGISTER |=> brightnessValue_r == $past(brightness_r);
	endproperty
	a_src: assert property (p_src) else $error("brightness source wrong");
	property p_timeout;
		@(posedge ref_clk) disable iff (rst)
		tmoEvt |=> flags_r[0][bl_reg_pkg::SERIAL_ERR_BIT] && tmoHold_r && !sdaOe;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not flagged");
	c_write: cover property (@(posedge ref_clk) disable iff (rst) wrEvt && writeAllowed);
	c_read: cover property (@(posedge scl) disable iff (rst) state_r == bl_reg_pkg::LS_RDATA);
	c_timeout: cover property (@(posedge ref_clk) disable iff (rst) tmoEvt);
	c_irq: cover property (@(posedge ref_clk) disable iff (rst) $rose(faultIrq_r));
endmodule

/* File: i2c_host_model.sv */
// Serial host model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the wire, which is high unless some party pulls it.
`timescale 1ns/1ps
module i2c_host_model (
	output logic scl,
	output logic pullLow,
	input wire logic sda
);
	logic [16:0] result;
	event doneEv;
	// The clock stands high and the line is released between frames.
	initial
	begin
		scl = 1'b1;
		pullLow = 1'b0;
	end
	// One 160 ns bit slot; data moves only while the clock is low.
	task automatic bitIo(input logic b, output logic s);
		pullLow = ~b;
		#40 scl = 1'b1;
		#40 s = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	// Start or repeated start: the line falls while the clock is high.
	task automatic start();
		pullLow = 1'b0;
		#40 scl = 1'b1;
		#40 pullLow = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask
	// Stop: the line rises while the clock is high, then the bus idles.
	task automatic stop();
		pullLow = 1'b1;
		#40 scl = 1'b1;
		#40 pullLow = 1'b0;
		#80;
	endtask
	task automatic byteIo(input logic [7:0] d, input logic a, output logic [7:0] r,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitIo(d[i], r[i]);
		bitIo(a, s);
		ack = ~s;
	endtask
	task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] ofs,
		input logic [15:0] wd);
		logic [7:0] hi;
		logic [7:0] lo;
		logic a;
		logic ok;
		start();
		byteIo({dev, 1'b0}, 1'b1, hi, ok);
		byteIo(ofs, 1'b1, hi, a);
		ok &= a;
		if (rd)
		begin
			start();
			byteIo({dev, 1'b1}, 1'b1, hi, a);
			ok &= a;
			// The last byte is refused so that the device lets go of the line.
			byteIo(8'hff, 1'b0, hi, a);
			byteIo(8'hff, 1'b1, lo, a);
		end
		else
		begin
			byteIo(wd[15:8], 1'b1, hi, a);
			ok &= a;
			byteIo(wd[7:0], 1'b1, lo, a);
			ok &= a;
			hi = 8'h00;
			lo = 8'h00;
		end
		stop();
		#400;
		result = {ok, hi, lo};
		->doneEv;
	endtask
	// A frame left hanging with the clock held low, then closed by a stop.
	task automatic stall(input logic [6:0] dev, input int ns);
		logic [7:0] r;
		logic a;
		start();
		byteIo({dev, 1'b0}, 1'b1, r, a);
		#(ns);
		stop();
		#400;
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the backlight serial register block.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/1ps
module tb;
	localparam int TMO = 2000;
	logic ref_clk, rst, addrSelect, writeAllowed, enableLevel, sdaOut, sdaOe, faultIrq;
	logic scl, pullLow, sdaIn;
	logic [15:0] brightnessValue, cfgOneWord, cfgTwoWord, seed;
	logic [11:0] currentSetting;
	logic [2:0] ditherSelect;
	logic [95:0] pool;
	bl_reg_pkg::fault_s faultIn;
	bl_reg_pkg::diag_s diagIn;
	logic [16:0] expQ[$];
	int fails;
	int checks;
	// Open-drain data wire with a pull-up.
	assign sdaIn = ~(pullLow | sdaOe);
	backlight_i2c_regs #(.TIMEOUT_CYCLES(TMO)) dut (.ref_clk(ref_clk), .rst(rst), .scl(scl),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(addrSelect),
		.writeAllowed(writeAllowed), .enableLevel(enableLevel), .faultIn(faultIn),
		.diagIn(diagIn), .brightnessValue(brightnessValue), .currentSetting(currentSetting),
		.ditherSelect(ditherSelect), .cfgOneWord(cfgOneWord), .cfgTwoWord(cfgTwoWord),
		.faultIrq(faultIrq));
	i2c_host_model host (.scl(scl), .pullLow(pullLow), .sda(sdaIn));
	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] e);
		checks++;
		if (seen !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Each access notes its expected reply before the host runs the frame.
	task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
		expQ.push_back(17'h10000);
		host.xfer(addrSelect ? 7'h3b : 7'h3a, 1'b0, ofs, d);
	endtask
	task automatic rd(input logic [7:0] ofs, input logic [15:0] e);
		expQ.push_back({1'b1, e});
		host.xfer(addrSelect ? 7'h3b : 7'h3a, 1'b1, ofs, 16'h0000);
	endtask
	task automatic pulse(input int k);
		@(negedge ref_clk);
		faultIn[k] = 1'b1;
		@(negedge ref_clk);
		faultIn[k] = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask
	// 40 MHz reference clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Watchdog, about three times the expected run length.
	initial
	begin
		#1000000;
		fails++;
		summarize();
	end
	// Every frame that xfer finishes is compared with the oldest note.
	initial
	begin
		forever
		begin
			@(host.doneEv);
			check("reply", host.result, expQ.pop_front());
		end
	end
	// Main sequence; the bench moves inputs on the falling edge only.
	initial
	begin
		rst = 1'b1;
		addrSelect = 1'b0;
		writeAllowed = 1'b1;
		enableLevel = 1'b1;
		faultIn = '0;
		diagIn = '0;
		seed = 16'h000c;
		for (int i = 0; i < 6; i++)
		begin
			seed = nextRand(seed);
			pool[i*16 +: 16] = seed;
		end
		seed = nextRand(seed);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		diagIn = pool[85:0];
		repeat (8) @(negedge ref_clk);
		check("current", currentSetting, 12'hfff);
		check("dither", ditherSelect, 3'h1);
		check("cfgOne", cfgOneWord, 16'h08a3);
		check("cfgTwo", cfgTwoWord, 16'h0001);
		check("bright", brightnessValue, diagIn.pwmInputDuty);
		check("irq", faultIrq, 1'b0);
		rd(8'h00, 16'h0000);
		rd(8'h0c, 16'haaaa);
		expQ.push_back(17'h0ffff);
		host.xfer(7'h3b, 1'b1, 8'h00, 16'h0000);
		@(negedge ref_clk);
		addrSelect = 1'b1;
		repeat (8) @(negedge ref_clk);
		expQ.push_back(17'h0ffff);
		host.xfer(7'h3a, 1'b1, 8'h00, 16'h0000);
		wr(8'h00, seed);
		check("bright", brightnessValue, diagIn.pwmInputDuty);
		wr(8'h04, 16'h020e);
		check("dither", ditherSelect, 3'h7);
		check("bright", brightnessValue, seed);
		wr(8'h20, 16'h1234);
		rd(8'h00, seed);
		@(negedge ref_clk);
		enableLevel = 1'b0;
		repeat (4) @(negedge ref_clk);
		check("bright", brightnessValue, 16'h0000);
		enableLevel = 1'b1;
		writeAllowed = 1'b0;
		wr(8'h02, 16'h0123);
		rd(8'h02, 16'h0fff);
		@(negedge ref_clk);
		writeAllowed = 1'b1;
		wr(8'h02, 16'h0123);
		check("current", currentSetting, 12'h123);
		wr(8'h14, 16'hffff);
		rd(8'h14, diagIn.stateMachineNow);
		rd(8'h16, diagIn.pwmInputDuty);
		rd(8'h18, diagIn.pwmOutputDuty);
		rd(8'h1a, {4'h0, diagIn.appliedCurrentCode});
		rd(8'h1c, {6'h00, diagIn.boostTargetCode});
		rd(8'h1e, diagIn.detectResult);
		pulse(0);
		check("irq", faultIrq, 1'b1);
		rd(8'h12, 16'h0002);
		wr(8'h12, 16'h0002);
		rd(8'h12, 16'h0002);
		wr(8'h12, 16'h0003);
		rd(8'h12, 16'h0000);
		check("irq", faultIrq, 1'b0);
		wr(8'h0c, 16'h0001);
		rd(8'h0c, 16'haaa8);
		pulse(0);
		check("irq", faultIrq, 1'b0);
		wr(8'h12, 16'h0003);
		wr(8'h0c, 16'h0003);
		rd(8'h0c, 16'haaaa);
		wr(8'h06, 16'h0000);
		pulse(16);
		check("irq", faultIrq, 1'b0);
		wr(8'h0e, 16'h0003);
		wr(8'h06, 16'h0001);
		host.stall(7'h3b, TMO * 25 + 5000);
		rd(8'h0e, 16'h8000);
		check("irq", faultIrq, 1'b1);
		// Let the watcher take the last reply before the verdict.
		@(negedge ref_clk);
		check("pending", 17'(expQ.size()), 17'h00000);
		summarize();
	end
endmodule
